// >>> hw/fdio_apb.sv
// APB slave register file for the image window block.
// Assumes zero-wait access: pready is high in every access phase.
`include "fdio_params.svh"
module fdio_apb
	import fdio_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] status_word,
	output logic [31:0] image_offset,
	output logic [31:0] vblank_end,
	output logic [31:0] image_size,
	output logic [11:0] frame_width,
	output logic [1:0] mode,
	output logic enable
);
	logic wr;
	logic hit;
	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	always_comb begin
		hit = 1'b1;
		prdata = 32'h00000000;
		case (paddr)
			`FDIO_OFF_IMAGE_OFFSET: prdata = image_offset;
			`FDIO_OFF_VBLANK_END: prdata = vblank_end;
			`FDIO_OFF_IMAGE_SIZE: prdata = image_size;
			`FDIO_OFF_FRAME_WIDTH: prdata = {20'h00000, frame_width};
			`FDIO_OFF_CONTROL: prdata = {29'h00000000, enable, mode};
			`FDIO_OFF_STATUS: prdata = status_word;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !hit;
	always_ff @(posedge clk) begin
		if (rst) begin
			image_offset <= `FDIO_RESET_WORD;
			vblank_end <= `FDIO_RESET_WORD;
			image_size <= `FDIO_RESET_WORD;
			frame_width <= `FDIO_RESET_WIDTH;
			mode <= 2'h0;
			enable <= 1'b0;
		end else if (wr) begin
			case (paddr)
				`FDIO_OFF_IMAGE_OFFSET: image_offset <= pwdata & `FDIO_IMAGE_OFFSET_MASK;
				`FDIO_OFF_VBLANK_END: vblank_end <= pwdata & `FDIO_PAIR_MASK;
				`FDIO_OFF_IMAGE_SIZE: image_size <= pwdata & `FDIO_PAIR_MASK;
				`FDIO_OFF_FRAME_WIDTH: frame_width <= pwdata[11:0];
				`FDIO_OFF_CONTROL: begin
					mode <= pwdata[1:0];
					enable <= pwdata[2];
				end
				default: ;
			endcase
		end
	end
endmodule

// >>> hw/fdio_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module fdio_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// >>> hw/fdio_params.svh
// Offsets, field positions, reset values and sizes for the field 1 image window block.
// Included by the design files; definitions only.
`ifndef FDIO_PARAMS_SVH
`define FDIO_PARAMS_SVH
`define FDIO_OFF_IMAGE_OFFSET 12'h000
`define FDIO_OFF_VBLANK_END 12'h004
`define FDIO_OFF_IMAGE_SIZE 12'h008
`define FDIO_OFF_FRAME_WIDTH 12'h00C
`define FDIO_OFF_CONTROL 12'h010
`define FDIO_OFF_STATUS 12'h014
`define FDIO_NV_BIT 31
`define FDIO_NH_BIT 15
`define FDIO_VOFF_MSB 27
`define FDIO_VOFF_LSB 16
`define FDIO_HOFF_MSB 11
`define FDIO_HOFF_LSB 0
`define FDIO_IMAGE_OFFSET_MASK 32'h8FFF8FFF
`define FDIO_PAIR_MASK 32'h0FFF0FFF
`define FDIO_RESET_WORD 32'h00000000
`define FDIO_RESET_WIDTH 12'h5A0
`define FDIO_DEFAULT_PIXEL 16'h1080
`define FDIO_FIFO_DEPTH 16
`define FDIO_PIX_W 16
`endif

// >>> hw/fdio_pkg.sv
// Types shared by the field 1 image window block.
// Assumes fdio_params.svh for all numeric constants.
package fdio_pkg;
	typedef enum logic [1:0] {
		FDIO_MODE_RAW = 2'b00,
		FDIO_MODE_BT656 = 2'b01,
		FDIO_MODE_YC = 2'b10
	} fdio_mode_t;
	typedef enum logic [1:0] {
		FDIO_ST_WAIT = 2'b00,
		FDIO_ST_IMAGE = 2'b01,
		FDIO_ST_DONE = 2'b10
	} fdio_state_t;
endpackage

// >>> hw/fdio_window.sv
// Field 1 image window placement: image line/pixel counters, FIFO drain, output pixel.
// Assumes frame counters and field/active flags from the display timing logic, same clock.
//
// Operation
// - Positive vertical: line counter 1 at end+offset
// - Negative vertical: line counter 1 at end-offset
// - Image pixels only from image line one
// - Pixel counter cleared at line image start
// - Take FIFO pixels from horizontal offset point
// - Negative horizontal: restart at frame width minus offset
// - Default values before horizontal offset point
// - Horizontal offset forced even in BT.656/YC
// - Bit 31 negative vertical, ignored in raw
// - Bit 15 negative horizontal, ignored in raw
// - Reserved bits read zero, writes ignored
// - Vertical offset twelve bits at 27:16
// - Horizontal offset twelve bits at 11:0
// - Vblank end line from frame line counter
// - Stop pixels at image width, then defaults
`include "fdio_params.svh"
module fdio_window
	import fdio_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [11:0] FRAME_LINE,
	input wire logic [11:0] FRAME_PIXEL,
	input wire logic FIELD1,
	input wire logic ACTIVE_LINE,
	input wire logic ACTIVE_PIXEL,
	input wire logic [15:0] PIXEL_IN,
	input wire logic PIXEL_IN_VALID,
	output logic PIXEL_IN_READY,
	output logic [15:0] PIXEL_OUT,
	output logic PIXEL_OUT_IMAGE,
	output logic VERTICAL_BLANK
);
	typedef struct packed {
		logic [11:0] image_line_counter;
		logic [11:0] image_pixel_counter;
		fdio_state_t state;
		logic line_run;
		logic [15:0] pixel_out;
		logic pixel_image;
		logic vblank;
		logic underrun;
	} fdio_win_t;

	fdio_win_t cur;
	fdio_win_t nxt;
	logic [31:0] image_offset;
	logic [31:0] vblank_end;
	logic [31:0] image_size;
	logic [11:0] frame_width;
	logic [1:0] mode;
	logic enable;
	logic [15:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic [31:0] status_word;

	function automatic logic [11:0] fdio_even(input logic [11:0] v, input logic force_even);
		fdio_even = force_even ? {v[11:1], 1'b0} : v;
	endfunction

	logic coded;
	logic neg_v;
	logic neg_h;
	logic [11:0] voff;
	logic [11:0] hoff;
	logic [11:0] vend;
	logic [11:0] width;
	logic [11:0] first_line;
	logic [11:0] start_pixel;
	logic start_line;

	assign coded = (mode == FDIO_MODE_BT656) || (mode == FDIO_MODE_YC);
	assign neg_v = coded && image_offset[`FDIO_NV_BIT];
	assign neg_h = coded && image_offset[`FDIO_NH_BIT];
	assign voff = image_offset[`FDIO_VOFF_MSB:`FDIO_VOFF_LSB];
	assign hoff = fdio_even(image_offset[`FDIO_HOFF_MSB:`FDIO_HOFF_LSB], coded);
	assign vend = vblank_end[27:16];
	assign width = fdio_even(image_size[11:0], coded);
	assign first_line = neg_v ? (vend - voff) : (vend + voff);
	assign start_pixel = neg_h ? (frame_width - hoff) : hoff;
	assign start_line = FIELD1 && (FRAME_LINE == first_line);
	assign status_word = {4'h0, cur.image_line_counter, 4'h0, cur.image_pixel_counter}
		| {2'b00, cur.underrun, 29'h00000000};

	fdio_apb u_apb (
		.clk(CLOCK),
		.rst(RESET),
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.pwdata(PWDATA),
		.prdata(PRDATA),
		.pready(PREADY),
		.pslverr(PSLVERR),
		.status_word(status_word),
		.image_offset(image_offset),
		.vblank_end(vblank_end),
		.image_size(image_size),
		.frame_width(frame_width),
		.mode(mode),
		.enable(enable)
	);

	fdio_fifo #(
		.WIDTH(`FDIO_PIX_W),
		.DEPTH(`FDIO_FIFO_DEPTH)
	) u_fifo (
		.clk(CLOCK),
		.rst(RESET),
		.in_data(PIXEL_IN),
		.in_valid(PIXEL_IN_VALID),
		.in_ready(PIXEL_IN_READY),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	always_comb begin
		nxt = cur;
		fifo_pop = 1'b0;
		nxt.pixel_out = `FDIO_DEFAULT_PIXEL;
		nxt.pixel_image = 1'b0;
		// Vertical blank ends at the programmed line in field 1, starts again on any other inactive line
		if (FIELD1 && FRAME_LINE == vend) begin
			nxt.vblank = 1'b0;
		end else if (!ACTIVE_LINE) begin
			nxt.vblank = 1'b1;
		end
		if (!enable) begin
			nxt.state = FDIO_ST_WAIT;
			nxt.line_run = 1'b0;
		end else begin
			case (cur.state)
				FDIO_ST_WAIT: begin
					if (start_line) begin
						nxt.image_line_counter = 12'h001;
						nxt.state = FDIO_ST_IMAGE;
					end
				end
				FDIO_ST_IMAGE: begin
					if (!FIELD1) begin
						nxt.state = FDIO_ST_DONE;
						nxt.line_run = 1'b0;
					end else begin
						if (FRAME_PIXEL == start_pixel) begin
							nxt.image_pixel_counter = 12'h000;
							nxt.line_run = 1'b1;
						end
						if (cur.line_run && cur.image_pixel_counter == width) begin
							nxt.line_run = 1'b0;
						end else if (cur.line_run && (ACTIVE_PIXEL || neg_h)) begin
							fifo_pop = fifo_valid;
							nxt.pixel_out = fifo_valid ? fifo_data : `FDIO_DEFAULT_PIXEL;
							nxt.pixel_image = fifo_valid;
							nxt.underrun = cur.underrun | !fifo_valid;
							nxt.image_pixel_counter = cur.image_pixel_counter + 12'h001;
						end
						if (FRAME_PIXEL == frame_width && cur.line_run) begin
							nxt.line_run = 1'b0;
						end
						if (FRAME_PIXEL == 12'h000 && cur.image_line_counter != 12'hFFF
							&& FRAME_LINE != first_line) begin
							nxt.image_line_counter = cur.image_line_counter + 12'h001;
						end
					end
				end
				FDIO_ST_DONE: begin
					if (start_line) begin
						nxt.image_line_counter = 12'h001;
						nxt.state = FDIO_ST_IMAGE;
					end
				end
				default: nxt.state = FDIO_ST_WAIT;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			cur <= '{
				image_line_counter: 12'h000,
				image_pixel_counter: 12'h000,
				state: FDIO_ST_WAIT,
				line_run: 1'b0,
				pixel_out: `FDIO_DEFAULT_PIXEL,
				pixel_image: 1'b0,
				vblank: 1'b1,
				underrun: 1'b0
			};
		end else begin
			cur <= nxt;
		end
	end

	assign PIXEL_OUT = cur.pixel_out;
	assign PIXEL_OUT_IMAGE = cur.pixel_image;
	assign VERTICAL_BLANK = cur.vblank;
endmodule

// >>> verif/fdio_sink.sv
// Video sink: counts image pixels and checks they arrive in order.
// Assumes the feeder counts up from zero after each reset.
module fdio_sink (
	input wire logic clk,
	input wire logic rst,
	input wire logic image,
	input wire logic [15:0] pix
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	int bad;
	logic [15:0] nxt;
	always @(posedge clk) begin
		if (rst) begin
			cnt <= 0;
			bad <= 0;
			nxt <= 16'h0000;
		end else if (image === 1'b1) begin
			cnt <= cnt + 1;
			nxt <= nxt + 16'h0001;
			if (pix !== nxt)
				bad <= bad + 1;
		end
	end
endmodule

// >>> verif/fdio_window_asserts.sv
// Checker for the field 1 image window ports.
// Bound to fdio_window; mirrors register writes from the APB port.
module fdio_window_asserts (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [11:0] FRAME_LINE,
	input wire logic [11:0] FRAME_PIXEL,
	input wire logic FIELD1,
	input wire logic PIXEL_IN_VALID,
	input wire logic PIXEL_IN_READY,
	input wire logic [15:0] PIXEL_OUT,
	input wire logic PIXEL_OUT_IMAGE,
	input wire logic VERTICAL_BLANK
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] off;
	logic [11:0] vend, wid, fw, ho, st, rc;
	logic [1:0] mode;
	wire acc = PSEL && PENABLE && PREADY;
	wire cm = (mode == 2'h1) || (mode == 2'h2);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	assign ho = cm ? {off[11:1], 1'b0} : off[11:0];
	assign st = (off[15] && cm) ? fw - ho : ho;
	always_ff @(posedge CLOCK) begin
		rc <= (RESET || !PIXEL_OUT_IMAGE) ? 12'h000 : rc + 12'h001;
		if (RESET) begin
			{off, vend, wid, mode} <= '0;
			fw <= 12'h5A0;
		end else if (acc && PWRITE) begin
			case (PADDR)
			12'h000: off <= PWDATA;
			12'h004: vend <= PWDATA[27:16];
			12'h008: wid <= PWDATA[11:0];
			12'h00C: fw <= PWDATA[11:0];
			12'h010: mode <= PWDATA[1:0];
			default: ;
			endcase
		end
	end
	a_resv_zero: assert property (acc && !PWRITE && PADDR == 12'h000 |->
		PRDATA[30:28] == 3'h0 && PRDATA[14:12] == 3'h0) else $error("reserved bits set");
	a_default_pix: assert property (!PIXEL_OUT_IMAGE |-> PIXEL_OUT == 16'h1080)
		else $error("no default pixel");
	a_first_field: assert property ($rose(PIXEL_OUT_IMAGE) |-> $past(FIELD1, 2))
		else $error("image outside field");
	a_start_point: assert property ($rose(PIXEL_OUT_IMAGE) |-> $past(FRAME_PIXEL, 2) == st)
		else $error("bad start pixel");
	a_stop_width: assert property ($fell(PIXEL_OUT_IMAGE) && $past(FIELD1) |->
		rc == (cm ? {wid[11:1], 1'b0} : wid)) else $error("bad run length");
	a_vblank_end: assert property ($fell(VERTICAL_BLANK) |-> $past(FRAME_LINE) == vend)
		else $error("bad blank end");
	a_unmapped_err: assert property (acc && PADDR > 12'h014 |-> PSLVERR)
		else $error("no slave error");
	a_inready_fall: assert property ($fell(PIXEL_IN_READY) |-> $past(PIXEL_IN_VALID))
		else $error("ready fell idle");
	cover property ($rose(PIXEL_OUT_IMAGE));
	cover property (acc && PSLVERR);
	cover property (!PIXEL_IN_READY);
endmodule
bind fdio_window fdio_window_asserts chk (.*);

// >>> verif/tb_fdio_window.sv
// Bench for the field 1 image window: APB tasks and whole-frame runs.
// Drives the frame counters itself; the sink checks image pixel order.
module tb_fdio_window;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLOCK, RESET, PSEL, PENABLE, PWRITE, FIELD1, ACTIVE_LINE, ACTIVE_PIXEL;
	logic PIXEL_IN_VALID, PREADY, PSLVERR, PIXEL_IN_READY, PIXEL_OUT_IMAGE, VERTICAL_BLANK;
	logic [11:0] PADDR, FRAME_LINE, FRAME_PIXEL;
	logic [31:0] PWDATA, PRDATA;
	logic [15:0] PIXEL_IN, PIXEL_OUT;
	int error_cnt = 0;
	int cmp_count = 0;
	fdio_window uut (.*);
	fdio_sink snk (.clk(CLOCK), .rst(RESET), .image(PIXEL_OUT_IMAGE), .pix(PIXEL_OUT));
	initial begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end
	// Feeder keeps the FIFO topped up
	always @(posedge CLOCK) begin
		PIXEL_IN_VALID <= !RESET;
		if (RESET)
			PIXEL_IN <= 16'h0000;
		else if (PIXEL_IN_VALID && PIXEL_IN_READY)
			PIXEL_IN <= PIXEL_IN + 16'h0001;
	end
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [32:0] r);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 40);
		r = {PSLVERR, PRDATA};
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 40)
			chk(0, 1);
		@(posedge CLOCK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [32:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
		logic [32:0] r;
		apb(1'b0, a, 32'h00000000, r);
		chk(r & m, e);
	endtask
	task automatic reset_dut();
		RESET <= 1'b1;
		repeat (8) @(posedge CLOCK);
		RESET <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic cfg(input logic [31:0] off, input logic [31:0] ctl);
		reset_dut();
		wr(12'h004, 32'h00050000);
		wr(12'h008, 32'h00000004);
		wr(12'h00C, 32'h00000014);
		wr(12'h000, off);
		wr(12'h010, ctl);
		repeat (2) @(posedge CLOCK);
		@(negedge CLOCK);
		chk(PIXEL_IN_READY, 0);
		@(posedge CLOCK);
	endtask
	task automatic frame(input int n, input int first);
		int fl;
		fl = 0;
		for (int l = 0; l < 12; l++) begin
			for (int p = 0; p < 20; p++) begin
				FRAME_LINE <= l[11:0];
				FRAME_PIXEL <= p[11:0];
				FIELD1 <= (l < 10);
				ACTIVE_LINE <= (l < 10);
				ACTIVE_PIXEL <= (p < 18);
				@(negedge CLOCK);
				if (PIXEL_OUT_IMAGE === 1'b1 && fl == 0)
					fl = l;
				@(posedge CLOCK);
			end
		end
		chk(snk.cnt, n);
		chk(snk.bad, 0);
		chk(fl, first);
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{PSEL, PENABLE, PWRITE, FIELD1, ACTIVE_LINE} = '0;
		{PADDR, FRAME_LINE, FRAME_PIXEL, PWDATA} = '0;
		ACTIVE_PIXEL = 1'b1;
		RESET = 1'b1;
		reset_dut();
		rd(12'h000, 33'h000000000, 33'h1FFFFFFFF);
		rd(12'h00C, 33'h0000005A0, 33'h1FFFFFFFF);
		wr(12'h000, 32'hFFFFFFFF);
		rd(12'h000, 33'h08FFF8FFF, 33'h1FFFFFFFF);
		rd(12'h020, 33'h100000000, 33'h100000000);
		cfg(32'h00020003, 32'h00000005);
		frame(12, 7);
		rd(12'h014, 33'h000030004, 33'h1FFFFFFFF);
		cfg(32'h80020003, 32'h00000005);
		frame(28, 3);
		cfg(32'h80020003, 32'h00000004);
		frame(12, 7);
		cfg(32'h00008002, 32'h00000006);
		// Last run is cut short when field 1 ends
		frame(17, 6);
		cfg(32'h00020003, 32'h00000001);
		frame(0, 0);
		tally_and_finish();
	end
	initial begin
		#400000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
